// ---- hw/absr_host.sv ----
`timescale 1ns/1ps
module absr_host
  import absr_pkg::*;
#(
  parameter int POWERUP_CYCLES = PWRUP_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // user request
  input wire logic req,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  // user answer
  output logic ready,
  output logic rd_valid,
  output logic [DATA_W-1:0] rd_data,
  // memory control pins
  output logic [ADDR_W-1:0] byte_address,
  output logic chip_select_n,
  output logic output_gate_n,
  output logic write_strobe_n,
  // memory data pins
  input wire logic [DATA_W-1:0] data_io_lines_in,
  output logic [DATA_W-1:0] data_io_lines_out,
  output logic data_io_lines_oe
);
  absr_state_t state_q;
  absr_state_t state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic cs_n_q;
  logic cs_n_d;
  logic oe_n_q;
  logic oe_n_d;
  logic we_n_q;
  logic we_n_d;
  logic [DATA_W-1:0] dout_q;
  logic [DATA_W-1:0] dout_d;
  logic doe_q;
  logic doe_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  logic ready_q;
  logic ready_d;
  logic pwr_done_q;
  logic pwr_done_d;

  absr_rd_if rd_if ();

  assign rd_if.pin_level = data_io_lines_in;

  absr_sync u_sync (
    .clk(clk),
    .reset(reset),
    .rd(rd_if.sync)
  );

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    addr_d = addr_q;
    cs_n_d = cs_n_q;
    oe_n_d = oe_n_q;
    we_n_d = we_n_q;
    dout_d = dout_q;
    doe_d = doe_q;
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    pwr_done_d = pwr_done_q;
    case (state_q)
      ST_POWERUP: begin
        // pins stay idle until the memory has settled
        if (cnt_q == CNT_RESET) begin
          pwr_done_d = 1'b1;
          state_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q - 16'h0001;
        end
      end
      ST_IDLE: begin
        if (req) begin
          addr_d = req_addr;
          cs_n_d = 1'b0;
          if (req_write) begin
            // gate stays high so the memory never drives against us
            oe_n_d = 1'b1;
            dout_d = req_wdata;
            doe_d = 1'b1;
            state_d = ST_WR_SETUP;
          end else begin
            // strobe high keeps the memory reading
            oe_n_d = 1'b0;
            we_n_d = 1'b1;
            cnt_d = CNT_W'(RD_WAIT_CYC - 1);
            state_d = ST_RD_WAIT;
          end
        end
      end
      ST_RD_WAIT: begin
        // address, select and gate all move together, so the longest access wins;
        // one spare cycle covers data arriving right at the edge
        if (cnt_q == CNT_RESET) begin
          rdata_d = rd_if.synced;
          rvalid_d = 1'b1;
          cs_n_d = 1'b1;
          oe_n_d = 1'b1;
          state_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q - 16'h0001;
        end
      end
      ST_WR_SETUP: begin
        // select fell a cycle earlier, so the strobe edge starts the write
        we_n_d = 1'b0;
        cnt_d = CNT_W'(WR_PULSE_CYC - 1);
        state_d = ST_WR_PULSE;
      end
      ST_WR_PULSE: begin
        if (cnt_q == CNT_RESET) begin
          we_n_d = 1'b1;
          cnt_d = CNT_W'(WR_HOLD_CYC - 1);
          state_d = ST_WR_HOLD;
        end else begin
          cnt_d = cnt_q - 16'h0001;
        end
      end
      ST_WR_HOLD: begin
        // address, select and data held past the strobe rise
        if (cnt_q == CNT_RESET) begin
          cs_n_d = 1'b1;
          doe_d = 1'b0;
          state_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q - 16'h0001;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // a request is only taken in idle, and ready is high in exactly the idle cycles
    ready_d = (state_d == ST_IDLE) && !(state_q == ST_IDLE && req);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_POWERUP;
      cnt_q <= CNT_W'(POWERUP_CYCLES - 1);
      addr_q <= ADDR_RESET;
      cs_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      dout_q <= DATA_RESET;
      doe_q <= 1'b0;
      rdata_q <= DATA_RESET;
      rvalid_q <= 1'b0;
      ready_q <= 1'b0;
      pwr_done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      cs_n_q <= cs_n_d;
      oe_n_q <= oe_n_d;
      we_n_q <= we_n_d;
      dout_q <= dout_d;
      doe_q <= doe_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      ready_q <= ready_d;
      pwr_done_q <= pwr_done_d;
    end
  end

  assign ready = ready_q;
  assign rd_valid = rvalid_q;
  assign rd_data = rdata_q;
  assign byte_address = addr_q;
  assign chip_select_n = cs_n_q;
  assign output_gate_n = oe_n_q;
  assign write_strobe_n = we_n_q;
  assign data_io_lines_out = dout_q;
  assign data_io_lines_oe = doe_q;

  a_pulse_width_min: assert property (@(posedge clk) disable iff (reset)
    $fell(we_n_q) |-> !we_n_q [*2] ##1 we_n_q)
    else $error("write strobe pulse not two cycles");

  a_addr_hold_rise: assert property (@(posedge clk) disable iff (reset)
    $rose(we_n_q) |-> $stable(addr_q) && !cs_n_q ##1 $stable(addr_q))
    else $error("address or select not held past strobe rise");

  a_strobe_ends_write: assert property (@(posedge clk) disable iff (reset)
    $rose(cs_n_q) |-> we_n_q && $past(we_n_q))
    else $error("select released before strobe ended write");

  a_data_hold_rise: assert property (@(posedge clk) disable iff (reset)
    $rose(we_n_q) |-> doe_q && $stable(dout_q) ##1 $stable(dout_q))
    else $error("write data not held after strobe rise");

  a_data_during_pulse: assert property (@(posedge clk) disable iff (reset)
    !we_n_q |-> doe_q && $past(doe_q))
    else $error("write data not driven ahead of strobe");

  a_gate_high_write: assert property (@(posedge clk) disable iff (reset)
    (doe_q || !we_n_q) |-> oe_n_q)
    else $error("output gate low while host drives data");

  a_no_early_access: assert property (@(posedge clk) disable iff (reset)
    !pwr_done_q |-> cs_n_q && we_n_q && !ready_q)
    else $error("access before power-up wait ended");

  a_read_strobe_high: assert property (@(posedge clk) disable iff (reset)
    $fell(oe_n_q) |-> we_n_q [*6] ##1 rvalid_q)
    else $error("read not answered after six cycles with strobe high");
endmodule : absr_host

// ---- hw/absr_sync.sv ----
`timescale 1ns/1ps
module absr_sync
  import absr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // levels in and out
  absr_rd_if.sync rd
);
  logic [DATA_W-1:0] meta_q;
  logic [DATA_W-1:0] meta_d;
  logic [DATA_W-1:0] sync_q;
  logic [DATA_W-1:0] sync_d;

  // meta_q is read by sync_q only
  always_comb begin
    meta_d = rd.pin_level;
    sync_d = meta_q;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_q <= DATA_RESET;
      sync_q <= DATA_RESET;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign rd.synced = sync_q;
endmodule : absr_sync

// ---- pkg/absr_pkg.sv ----
package absr_pkg;
  // pin widths of the memory and the counter width
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int CNT_W = 16;

  // host clock
  localparam int CLK_PERIOD_NS = 40;

  // device timing, slowest speed grade, in ns except the power-up delay in ms
  localparam int ADDRESS_TO_DATA_DELAY_NS = 120;
  localparam int SELECT_TO_DATA_DELAY_NS = 60;
  localparam int GATE_TO_DATA_DELAY_NS = 60;
  localparam int WRITE_PULSE_WIDTH_NS = 45;
  localparam int ADDRESS_HOLD_TIME_NS = 40;
  localparam int WRITE_DATA_HOLD_NS = 15;
  localparam int POWERUP_DELAY_MS = 2;

  // synchroniser depth on the data lines
  localparam int SYNC_STAGES = 2;

  // least times round up to whole cycles
  localparam int ACCESS_NS_MAX = (ADDRESS_TO_DATA_DELAY_NS > SELECT_TO_DATA_DELAY_NS) ?
    ADDRESS_TO_DATA_DELAY_NS : SELECT_TO_DATA_DELAY_NS;
  localparam int ACCESS_CYC = (ACCESS_NS_MAX + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RD_WAIT_CYC = ACCESS_CYC + SYNC_STAGES + 1;
  localparam int WR_PULSE_CYC = (WRITE_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_NS_MAX = (ADDRESS_HOLD_TIME_NS > WRITE_DATA_HOLD_NS) ?
    ADDRESS_HOLD_TIME_NS : WRITE_DATA_HOLD_NS;
  localparam int WR_HOLD_CYC = (HOLD_NS_MAX + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PWRUP_CYC = (POWERUP_DELAY_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // address and data values after reset, and the end value of the counter
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 10'h000;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

  typedef enum logic [2:0] {
    ST_POWERUP,
    ST_IDLE,
    ST_RD_WAIT,
    ST_WR_SETUP,
    ST_WR_PULSE,
    ST_WR_HOLD
  } absr_state_t;
endpackage : absr_pkg

// ---- pkg/absr_rd_if.sv ----
`timescale 1ns/1ps
interface absr_rd_if;
  import absr_pkg::*;
  logic [DATA_W-1:0] pin_level;
  logic [DATA_W-1:0] synced;
  modport sync (input pin_level, output synced);
  modport ctl (output pin_level, input synced);
endinterface : absr_rd_if

// ---- testbench/absr_mem_model.sv ----
`timescale 1ns/1ps
module absr_mem_model
  import absr_pkg::*;
#(
  parameter int ACC_NS = ADDRESS_TO_DATA_DELAY_NS,
  parameter int PWR_NS = 320
) (
  // memory pins
  input wire logic [ADDR_W-1:0] byte_address,
  input wire logic chip_select_n,
  input wire logic output_gate_n,
  input wire logic write_strobe_n,
  input wire logic [DATA_W-1:0] data_io_lines,
  // drive back and host faults seen
  output logic [DATA_W-1:0] mem_data,
  output logic mem_oe,
  output int viol
);
  logic [DATA_W-1:0] store [0:1023];
  logic [ADDR_W-1:0] wr_addr;
  logic settled;
  time t_chg, t_wr;
  initial begin
    viol = 0;
    t_chg = 0;
    t_wr = 0;
  end
  always @(byte_address, chip_select_n, output_gate_n) t_chg = $time;
  // 1 ns poll keeps the model short at some cost in run time
  always #1 settled = ($time - t_chg) >= ACC_NS;
  assign mem_oe = !chip_select_n && !output_gate_n && write_strobe_n;
  // unsettled data shows inverted so a stale byte never passes
  assign mem_data = settled ? store[byte_address] : ~store[byte_address];
  always @(negedge chip_select_n) begin
    if ($time < PWR_NS) viol++;
  end
  always @(negedge write_strobe_n, negedge chip_select_n) begin
    if (!write_strobe_n && !chip_select_n) begin
      wr_addr = byte_address;
      t_wr = $time;
      if (!output_gate_n) viol++;
    end
  end
  always @(posedge write_strobe_n) begin
    if (!chip_select_n) begin
      if ($time - t_wr < WRITE_PULSE_WIDTH_NS) viol++;
      store[wr_addr] = data_io_lines;
    end
  end
endmodule : absr_mem_model

// ---- testbench/test_async_byte_static_ram.sv ----
`timescale 1ns/1ps
module test_async_byte_static_ram;
  import absr_pkg::*;
  localparam int PWR = 8;
  logic clk, reset, req, req_write, ready, rd_valid;
  logic chip_select_n, output_gate_n, write_strobe_n, data_io_lines_oe, mem_oe;
  logic [ADDR_W-1:0] req_addr, byte_address;
  logic [DATA_W-1:0] req_wdata, rd_data, data_io_lines_out, mem_data, bus, last_bus;
  int viol, errors, samples_checked;
  int ref_mem[int];
  logic [31:0] lfsr;
  logic [ADDR_W-1:0] addr_q[$];
  // released bus shows the inverse of its last level
  assign bus = data_io_lines_oe ? data_io_lines_out : (mem_oe ? mem_data : ~last_bus);
  always @(bus) if (data_io_lines_oe || mem_oe) last_bus = bus;
  absr_host #(.POWERUP_CYCLES(PWR)) u_absr_host (.clk, .reset, .req, .req_write, .req_addr,
    .req_wdata, .ready, .rd_valid, .rd_data, .byte_address, .chip_select_n, .output_gate_n,
    .write_strobe_n, .data_io_lines_in(bus), .data_io_lines_out, .data_io_lines_oe);
  // power counts as applied at time zero, so the ten reset cycles are part of the wait
  absr_mem_model #(.PWR_NS((10 + PWR) * CLK_PERIOD_NS)) u_absr_mem_model (.byte_address,
    .chip_select_n, .output_gate_n, .write_strobe_n, .data_io_lines(bus), .mem_data, .mem_oe,
    .viol);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic chk_byte(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: read %h expected %h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic chk_bit(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s is %b", $time, what, got);
    end
  endtask : chk_bit
  task automatic stop_test();
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  task automatic op(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk_bit(ready, 1'b1, "ready");
    req = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    @(posedge clk);
    #1;
    chk_bit(chip_select_n, 1'b0, "select");
    chk_bit(output_gate_n, wr, "gate");
    chk_bit(data_io_lines_oe, wr, "drive");
    // a write held while busy must be ignored
    req_write = ~wr;
    req_wdata = ~d;
    if (wr) begin
      ref_mem[int'(a)] = int'(d);
      req = 1'b0;
    end else begin
      repeat (4) @(posedge clk);
      #1;
      req = 1'b0;
      @(posedge clk);
      #1;
      chk_bit(rd_valid, 1'b0, "early valid");
      @(posedge clk);
      #1;
      chk_bit(rd_valid, 1'b1, "valid");
      chk_byte(rd_data, DATA_W'(ref_mem[int'(a)]));
    end
  endtask : op
  always @(negedge clk) chk_bit(data_io_lines_oe & mem_oe, 1'b0, "contention");
  initial begin
    #(20000 * CLK_PERIOD_NS);
    errors++;
    $display("mismatch at %0t: timeout", $time);
    stop_test();
  end
  initial begin
    errors = 0;
    samples_checked = 0;
    lfsr = 32'h0694_1ca9;
    last_bus = 8'h00;
    reset = 1'b1;
    req = 1'b0;
    req_write = 1'b0;
    req_addr = 10'h000;
    req_wdata = 8'h00;
    repeat (10) @(posedge clk);
    #1;
    chk_bit(chip_select_n, 1'b1, "reset select");
    reset = 1'b0;
    repeat (PWR - 2) @(posedge clk);
    #1;
    chk_bit(ready, 1'b0, "early ready");
    $display("test powerup done");
    op(1'b1, 10'h000, 8'h5a);
    op(1'b1, 10'h3ff, 8'ha5);
    for (int i = 0; i < 16; i++) begin
      lfsr = lfsr_next(lfsr);
      addr_q.push_back(lfsr[ADDR_W-1:0]);
      op(1'b1, lfsr[ADDR_W-1:0], lfsr[DATA_W+15:16]);
    end
    op(1'b0, 10'h000, 8'h00);
    op(1'b0, 10'h3ff, 8'h00);
    foreach (addr_q[i]) op(1'b0, addr_q[i], 8'h00);
    $display("test random done");
    op(1'b1, 10'h155, 8'h00);
    op(1'b1, 10'h155, 8'hff);
    op(1'b0, 10'h155, 8'h00);
    $display("test overwrite done");
    req = 1'b1;
    req_write = 1'b0;
    req_addr = 10'h3ff;
    @(posedge clk);
    #1;
    req = 1'b0;
    @(posedge clk);
    #1;
    reset = 1'b1;
    #1;
    chk_bit(chip_select_n, 1'b1, "abort select");
    chk_bit(ready, 1'b0, "abort ready");
    @(posedge clk);
    #1;
    reset = 1'b0;
    op(1'b0, 10'h3ff, 8'h00);
    op(1'b0, 10'h155, 8'h00);
    $display("test abort done");
    chk_bit(viol == 0, 1'b1, "host timing");
    stop_test();
  end
endmodule : test_async_byte_static_ram
